// *** pkg/pmps_pkg.sv ***
package pmps_pkg;
  typedef enum logic [1:0] {
    M_INLINE = 2'b00,
    M_MIRROR = 2'b01,
    M_BYPASS = 2'b10,
    M_MGMT = 2'b11
  } pmps_mode_e;
  typedef enum logic [2:0] {
    P_RUN = 3'b000,
    P_FLUSH = 3'b001,
    P_BYP = 3'b010,
    P_STBY = 3'b011,
    P_OFF = 3'b100
  } pmps_pwr_e;
  typedef enum logic [1:0] {
    S_PRIM = 2'b00,
    S_IN2 = 2'b01,
    S_IN3 = 2'b10
  } pmps_src_e;
  typedef struct packed {
    logic ac_ok;
    logic in1_ok;
    logic in2_ok;
    logic in3_ok;
    logic batt_low;
    logic batt_dead;
  } pmps_pwr_s;
  typedef struct packed {
    logic [5:0] link;
    logic [5:0] fast;
  } pmps_phy_s;
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_BYP = 8'h08;
  localparam logic [7:0] A_CTRL = 8'h0c;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_SEL = 8'h14;
  localparam logic [7:0] A_IP = 8'h18;
  localparam logic [7:0] A_MACLO = 8'h1c;
  localparam logic [7:0] A_MACHI = 8'h20;
  localparam int CMD_MODE_LSB = 4;
  localparam int BYP_SEL_LSB = 4;
  localparam int CTRL_RETR_BIT = 8;
  localparam logic [5:0] RST_MARKER = 6'h3f;
  localparam logic RST_RETR = 1'b0;
  localparam pmps_pwr_s RST_PWR = 6'h20;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned STABLE_S = 15;
  localparam int unsigned STBY_CYC_DEF = STABLE_S * CLK_HZ;
  localparam int unsigned PRIM_MS = 100;
  localparam int unsigned PRIM_CYC_DEF = PRIM_MS * (CLK_HZ / 1000);
endpackage

// *** src/pmps_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (R01) inline pairs ports 1-2, 3-4, 5-6; traffic forwarded to partner
// (R02) malfunction or power loss moves inline ports to bypass
// (R03) mirror port only receives and records; never forwards or transmits
// (R04) mirror refuses retrieval/status; commands only with retrieval and marker
// (R05) marker off: all utility traffic on that port ignored
// (R06) inline on one port puts its partner inline too
// (R07) inline/bypass to mirror sets partner to management; may be overridden
// (R08) utility switches bypass on/off per pair; all pairs allowed
// (R09) every port bypassed: capture light off
// (R10) all bypassed plus fetch button: first pair back to inline
// (R11) management port never captures; carries utility traffic only; the code also enables ARP there (arp_en)
// (R12) management port answers only ARP and utility messages
// (R13) inline port takes commands and retrieval unless marker off
// (R14) orange lit at high speed, green on link; both dark in bypass
// (R15) per-port IP and MAC held, set by utility
// (R16) primary fails: switch to backup; return once primary stable
// (R17) battery undervoltage with no other source starts safe shutdown
// (R18) shutdown: flush, bypass all non-management ports, then standby
// (R19) standby: off if battery dead; resume after 15 s stable power
// (R20) resume from standby logs power restored
// (R21) stability timer restarts when power drops before interval ends
// (R22) partner changes land in the same cycle as the requested change
module pmps_top
  import pmps_pkg::*;
#(
  parameter int unsigned STBY_CYC = STBY_CYC_DEF,
  parameter int unsigned PRIM_CYC = PRIM_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pmps_pwr_s pwr_in,
  input wire pmps_phy_s phy_in,
  input wire logic fetch_button,
  input wire logic malfunction,
  input wire logic flush_done,
  output logic [5:0] fwd_en,
  output logic [5:0] tx_en,
  output logic [5:0] cap_en,
  output logic [5:0] cmd_en,
  output logic [5:0] query_en,
  output logic [5:0] arp_en,
  output logic [5:0] bypass_en,
  output logic [5:0] led_orange,
  output logic [5:0] led_green,
  output logic capture_active_light,
  output logic flush_req,
  output logic standby,
  output logic power_off,
  output logic log_restore,
  output logic [1:0] src_sel
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  pmps_pwr_s pw_s1, pw;
  pmps_phy_s phy_s1, phy;
  logic btn_s1, btn_s2, btn_s3;
  logic btn_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // mains assumed good until the stages fill: zeros would read as
      // a total power loss and throw every port into bypass
      pw_s1 <= RST_PWR;
      pw <= RST_PWR;
      phy_s1 <= '0;
      phy <= '0;
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
      btn_s3 <= 1'b0;
    end else begin
      pw_s1 <= pwr_in;
      pw <= pw_s1;
      phy_s1 <= phy_in;
      phy <= phy_s1;
      btn_s1 <= fetch_button;
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
    end
  end

  assign btn_rise = btn_s2 && !btn_s3;

  // ****************************************
  // power supervisor
  // ****************************************
  pmps_pwr_e pstate;
  pmps_src_e src;
  logic [31:0] stby_cnt, prim_cnt;
  logic [7:0] restore_cnt;
  logic prim_ok, prim_stable, alt_ok, undervolt, fault_now, resume;

  assign prim_ok = pw.ac_ok || pw.in1_ok;
  assign prim_stable = prim_cnt == PRIM_CYC;
  // a low battery is no alternative, so input 2 is left out
  assign alt_ok = prim_ok || pw.in3_ok;
  assign undervolt = pw.batt_low && !alt_ok; // [R17]
  assign fault_now = malfunction || !(alt_ok || pw.in2_ok);
  assign resume = pstate == P_STBY && alt_ok &&
                  stby_cnt == STBY_CYC - 32'd1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pstate <= P_RUN;
    end else begin
      unique case (pstate)
        P_RUN: if (undervolt) pstate <= P_FLUSH; // [R17]
        P_FLUSH: if (flush_done) pstate <= P_BYP; // [R18]
        P_BYP: pstate <= P_STBY; // [R18]
        P_STBY: begin
          if (pw.batt_dead) begin
            pstate <= P_OFF; // [R19]
          end else if (resume) begin
            pstate <= P_RUN; // [R19]
          end
        end
        P_OFF: pstate <= P_OFF;
        default: pstate <= P_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pstate != P_STBY || !alt_ok) begin
      stby_cnt <= '0; // [R21]
    end else begin
      stby_cnt <= stby_cnt + 32'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_restore <= 1'b0;
      restore_cnt <= '0;
    end else begin
      log_restore <= resume; // [R20]
      if (resume) restore_cnt <= restore_cnt + 8'd1; // [R20]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush_req <= 1'b0;
      standby <= 1'b0;
      power_off <= 1'b0;
      src_sel <= S_PRIM;
    end else begin
      flush_req <= pstate == P_FLUSH;
      standby <= pstate == P_STBY;
      power_off <= pstate == P_OFF;
      src_sel <= src;
    end
  end

  // hold-off keeps a bouncing primary from toggling the source
  always_ff @(posedge aclk) begin
    if (!aresetn || !prim_ok) begin
      prim_cnt <= '0;
    end else if (!prim_stable) begin
      prim_cnt <= prim_cnt + 32'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src <= S_PRIM;
    end else begin
      unique case (src)
        S_PRIM: begin
          if (!prim_ok && pw.in2_ok) src <= S_IN2; // [R16]
          else if (!prim_ok && pw.in3_ok) src <= S_IN3; // [R16]
        end
        S_IN2, S_IN3: begin
          if (prim_stable) src <= S_PRIM; // [R16]
          else if (src == S_IN2 && !pw.in2_ok && pw.in3_ok) src <= S_IN3;
          else if (src == S_IN3 && !pw.in3_ok && pw.in2_ok) src <= S_IN2;
        end
        default: src <= S_PRIM;
      endcase
    end
  end

  // ****************************************
  // port modes
  // ****************************************
  pmps_mode_e mode [6];
  pmps_mode_e next_mode [6];
  logic cmd_v, byp_v, retr_en, all_byp;
  logic [2:0] cmd_port, byp_on, byp_sel, sel;
  pmps_mode_e cmd_mode;
  logic [5:0] marker;

  always_comb begin
    all_byp = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (mode[i] != M_BYPASS) all_byp = 1'b0;
    end
  end

  // all sources merge here so pairs never show a half-applied state
  always_comb begin
    logic [2:0] p;
    logic [2:0] q;
    p = cmd_port;
    q = cmd_port ^ 3'd1;
    for (int i = 0; i < 6; i++) next_mode[i] = mode[i];
    if (cmd_v && cmd_port < 3'd6) begin
      unique case (cmd_mode)
        M_INLINE: begin
          next_mode[p] = M_INLINE;
          next_mode[q] = M_INLINE; // [R06] [R22]
        end
        M_MIRROR: begin
          next_mode[p] = M_MIRROR;
          if (mode[p] == M_INLINE || mode[p] == M_BYPASS) begin
            next_mode[q] = M_MGMT; // [R07] [R22]
          end
        end
        M_BYPASS, M_MGMT: next_mode[p] = cmd_mode;
      endcase
    end
    for (int k = 0; k < 3; k++) begin
      if (byp_v && byp_sel[k] && byp_on[k]) begin
        next_mode[2*k] = M_BYPASS; // [R08]
        next_mode[2*k+1] = M_BYPASS;
      end else if (byp_v && byp_sel[k] && mode[2*k] == M_BYPASS &&
                   mode[2*k+1] == M_BYPASS) begin
        next_mode[2*k] = M_INLINE; // [R08]
        next_mode[2*k+1] = M_INLINE;
      end
    end
    if (all_byp && btn_rise) begin
      next_mode[0] = M_INLINE; // [R10]
      next_mode[1] = M_INLINE;
    end
    for (int i = 0; i < 6; i++) begin
      if (fault_now && next_mode[i] == M_INLINE) begin
        next_mode[i] = M_BYPASS; // [R02]
      end
      if (pstate == P_BYP && next_mode[i] != M_MGMT) begin
        next_mode[i] = M_BYPASS; // [R18]
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      if (!aresetn) mode[i] <= M_INLINE;
      else mode[i] <= next_mode[i];
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      if (!aresetn) begin
        fwd_en[i] <= 1'b0;
        tx_en[i] <= 1'b0;
        cap_en[i] <= 1'b0;
        cmd_en[i] <= 1'b0;
        query_en[i] <= 1'b0;
        arp_en[i] <= 1'b0;
        bypass_en[i] <= 1'b0;
        led_orange[i] <= 1'b0;
        led_green[i] <= 1'b0;
      end else begin
        fwd_en[i] <= mode[i] == M_INLINE &&
                     mode[i^1] == M_INLINE; // [R01] [R03]
        tx_en[i] <= mode[i] == M_INLINE || mode[i] == M_MGMT; // [R03]
        cap_en[i] <= mode[i] == M_INLINE || mode[i] == M_MIRROR; // [R11]
        cmd_en[i] <= marker[i] && (mode[i] == M_INLINE ||
                     mode[i] == M_MGMT ||
                     (mode[i] == M_MIRROR && retr_en)); // [R04] [R05] [R13]
        query_en[i] <= marker[i] && (mode[i] == M_INLINE ||
                       mode[i] == M_MGMT); // [R04] [R05] [R13]
        arp_en[i] <= mode[i] == M_MGMT; // [R12]
        bypass_en[i] <= mode[i] == M_BYPASS;
        led_green[i] <= phy.link[i] && mode[i] != M_BYPASS; // [R14]
        led_orange[i] <= phy.link[i] && phy.fast[i] &&
                         mode[i] != M_BYPASS; // [R14]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) capture_active_light <= 1'b0;
    else capture_active_light <= !all_byp; // [R09]
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic [31:0] ip_tab [6];
  logic [31:0] maclo_tab [6];
  logic [15:0] machi_tab [6];
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      r[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == A_MODE || a == A_CMD || a == A_BYP || a == A_CTRL ||
           a == A_STAT || a == A_SEL || a == A_IP || a == A_MACLO ||
           a == A_MACHI;
  endfunction

  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok = addr_ok(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      marker <= RST_MARKER;
      retr_en <= RST_RETR;
      sel <= '0;
      cmd_v <= 1'b0;
      cmd_port <= '0;
      cmd_mode <= M_INLINE;
      byp_v <= 1'b0;
      byp_on <= '0;
      byp_sel <= '0;
    end else begin
      cmd_v <= do_wr && aw_addr == A_CMD && w_strb[0];
      byp_v <= do_wr && aw_addr == A_BYP && w_strb[0];
      if (do_wr && w_strb[0]) begin
        if (aw_addr == A_CMD) begin
          cmd_port <= w_data[2:0];
          cmd_mode <= pmps_mode_e'(w_data[CMD_MODE_LSB +: 2]);
        end
        if (aw_addr == A_BYP) begin
          byp_on <= w_data[2:0];
          byp_sel <= w_data[BYP_SEL_LSB +: 3];
        end
        if (aw_addr == A_CTRL) marker <= w_data[5:0]; // [R05]
        if (aw_addr == A_SEL) sel <= w_data[2:0];
      end
      if (do_wr && w_strb[1] && aw_addr == A_CTRL) begin
        retr_en <= w_data[CTRL_RETR_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      if (!aresetn) begin
        ip_tab[i] <= '0;
        maclo_tab[i] <= '0;
        machi_tab[i] <= '0;
      end else if (do_wr && sel == 3'(i)) begin
        if (aw_addr == A_IP) begin
          ip_tab[i] <= merge(ip_tab[i], w_data, w_strb); // [R15]
        end
        if (aw_addr == A_MACLO) begin
          maclo_tab[i] <= merge(maclo_tab[i], w_data, w_strb); // [R15]
        end
        if (aw_addr == A_MACHI) begin
          machi_tab[i] <= 16'(merge({16'h0000, machi_tab[i]},
                                    w_data, w_strb));
        end
      end
    end
  end

  always_comb begin
    logic [2:0] s;
    s = sel < 3'd6 ? sel : 3'd0;
    rd_word = '0;
    rd_ok = addr_ok({s_axi_araddr[7:2], 2'b00});
    case ({s_axi_araddr[7:2], 2'b00})
      A_MODE: begin
        for (int i = 0; i < 6; i++) rd_word[2*i +: 2] = mode[i];
      end
      A_CTRL: rd_word = {23'h000000, retr_en, 2'b00, marker};
      A_STAT: rd_word = {16'h0000, restore_cnt, capture_active_light,
                         all_byp, src, 1'b0, pstate};
      A_SEL: rd_word = {29'h00000000, sel};
      A_IP: rd_word = sel < 3'd6 ? ip_tab[s] : 32'h00000000;
      A_MACLO: rd_word = sel < 3'd6 ? maclo_tab[s] : 32'h00000000;
      A_MACHI: rd_word = sel < 3'd6 ? {16'h0000, machi_tab[s]} : 32'h0;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pair;
    cmd_v && cmd_mode == M_INLINE && cmd_port == 3'd1 && !fault_now &&
    pstate == P_RUN |=> mode[0] == M_INLINE && mode[1] == M_INLINE;
  endproperty
  a_pair: assert property (p_pair) else $error("partner not inline"); // [R06]
  property p_fault;
    fault_now && mode[2] == M_INLINE |=> mode[2] == M_BYPASS;
  endproperty
  a_fault: assert property (p_fault) else $error("no bypass"); // [R02]
  property p_mirror;
    mode[4] == M_MIRROR |=> !tx_en[4] && !fwd_en[4] && cap_en[4];
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror tx"); // [R03]
  property p_marker;
    !marker[2] |=> !cmd_en[2] && !query_en[2];
  endproperty
  a_marker: assert property (p_marker) else $error("marker off"); // [R05]
  property p_light;
    all_byp |=> !capture_active_light;
  endproperty
  a_light: assert property (p_light) else $error("light on"); // [R09]
  property p_fetch;
    all_byp && btn_rise && !cmd_v && !byp_v && !fault_now &&
    pstate == P_RUN |=> mode[0] == M_INLINE && mode[1] == M_INLINE;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch ignored"); // [R10]
  property p_led;
    mode[4] == M_BYPASS |=> !led_orange[4] && !led_green[4];
  endproperty
  a_led: assert property (p_led) else $error("led in bypass"); // [R14]
  property p_uv;
    pstate == P_RUN && undervolt |=> pstate == P_FLUSH ##1 flush_req;
  endproperty
  a_uv: assert property (p_uv) else $error("no shutdown"); // [R17]
  property p_timer;
    pstate == P_STBY && !alt_ok |=> stby_cnt == 32'd0;
  endproperty
  a_timer: assert property (p_timer) else $error("timer kept"); // [R21]
  property p_split;
    cmd_v && cmd_mode == M_MIRROR && cmd_port == 3'd0 &&
    mode[0] == M_INLINE && !fault_now && !byp_v && pstate == P_RUN
    |=> mode[0] == M_MIRROR && mode[1] == M_MGMT;
  endproperty
  a_split: assert property (p_split) else $error("no mgmt"); // [R07]
  c_shut: cover property (pstate == P_BYP ##1 pstate == P_STBY);
  c_fetch: cover property (all_byp && btn_rise);
  c_src: cover property (src == S_PRIM ##1 src == S_IN2);
  c_resume: cover property (log_restore);

endmodule
`default_nettype wire

// *** test/pmps_store_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// storage side of the shutdown flush; answers promptly or slowly
module pmps_store_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic flush_req,
  output logic flush_done
);
  int cnt;
  // done only while asked, so a stale pulse cannot end a later flush
  always_ff @(posedge aclk) begin
    if (!aresetn || !flush_req) begin
      cnt <= 0;
      flush_done <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      flush_done <= (cnt == (slow ? 12 : 1));
    end
  end
endmodule
`default_nettype wire

// *** test/pmps_top_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module pmps_top_tb_top;
  import pmps_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, fetch = 0, malf = 0;
  logic slow = 1, fdone, flush_req, standby, power_off, log_restore, cal;
  logic awr, wr_rdy, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rd_data;
  logic [1:0] br, rr, brsp, rrsp, src_sel;
  logic [5:0] fwd, tx, cap, cmd, qry, arp, byp, lo, lg;
  pmps_pwr_s pwr = 6'h20;
  pmps_phy_s phy = 12'hfff;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  always #4 aclk = ~aclk;
  pmps_top #(.STBY_CYC(50), .PRIM_CYC(20)) pmps_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .pwr_in(pwr), .phy_in(phy), .fetch_button(fetch),
    .malfunction(malf), .flush_done(fdone), .fwd_en(fwd), .tx_en(tx),
    .cap_en(cap), .cmd_en(cmd), .query_en(qry), .arp_en(arp),
    .bypass_en(byp), .led_orange(lo), .led_green(lg),
    .capture_active_light(cal), .flush_req(flush_req), .standby(standby),
    .power_off(power_off), .log_restore(log_restore), .src_sel(src_sel));
  pmps_store_model pmps_store_model_inst (.aclk(aclk), .aresetn(aresetn),
    .slow(slow), .flush_req(flush_req), .flush_done(fdone));
  // ****************
  // bus cycles
  // ****************
  // bready/rready stay high: every answer is taken at the edge it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!bv);
    brsp = br;
  endtask
  task automatic rd(input logic [7:0] a);
    ara <= a; arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    rd_data = rdat; rrsp = rr;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic cmdw(input logic [7:0] a, input logic [31:0] d);
    wr(a, d); wt(3);
  endtask
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd(A_MODE); `CHK(rd_data, 32'h0)
    `CHK(fwd, 6'h3f)
    rd(A_CTRL); `CHK(rd_data, 32'h3f)
    wr(8'h40, 32'h1); `CHK(brsp, RESP_SLVERR)
    rd(8'h40); `CHK(rrsp, RESP_SLVERR)
    `CHK(lg, 6'h3f)
    `CHK(lo, 6'h3f)
  endtask
  task automatic t_mirror();
    cmdw(A_CMD, 32'h10);
    rd(A_MODE); `CHK(rd_data, 32'hd)
    `CHK(fwd, 6'h3c)
    `CHK(tx[0], 1'b0)
    `CHK(cap[1:0], 2'b01)
    `CHK(arp, 6'h02)
    `CHK(qry[0], 1'b0)
    `CHK(cmd[0], 1'b0)
    cmdw(A_CTRL, 32'h13f);
    `CHK(cmd[0], 1'b1)
    cmdw(A_CMD, 32'h11);
    rd(A_MODE); `CHK(rd_data, 32'h5)
    cmdw(A_CMD, 32'h01);
    rd(A_MODE); `CHK(rd_data, 32'h0)
  endtask
  task automatic t_marker();
    cmdw(A_CTRL, 32'h13b);
    `CHK(cmd, 6'h3b)
    `CHK(qry, 6'h3b)
    cmdw(A_CTRL, 32'h13f);
  endtask
  task automatic t_bypass();
    cmdw(A_BYP, 32'h77);
    `CHK(byp, 6'h3f)
    `CHK(cal, 1'b0)
    `CHK({lg, lo}, 12'h000)
    fetch <= 1'b1; wt(8); fetch <= 1'b0; wt(3);
    rd(A_MODE); `CHK(rd_data, 32'haa0)
    `CHK(cal, 1'b1)
    cmdw(A_BYP, 32'h70);
    rd(A_MODE); `CHK(rd_data, 32'h0)
  endtask
  task automatic t_fault();
    malf <= 1'b1; wt(1); malf <= 1'b0; wt(3);
    rd(A_MODE); `CHK(rd_data, 32'haaa)
    cmdw(A_BYP, 32'h70);
  endtask
  task automatic t_addr();
    wr(A_SEL, 32'h2); wr(A_IP, 32'hc0a80005); wr(A_MACLO, 32'h11223344);
    wr(A_SEL, 32'h3); wr(A_IP, 32'h0a000001); wr(A_SEL, 32'h2);
    rd(A_IP); `CHK(rd_data, 32'hc0a80005)
    rd(A_MACLO); `CHK(rd_data, 32'h11223344)
    wr(A_SEL, 32'h6); rd(A_IP); `CHK(rd_data, 32'h0)
  endtask
  task automatic t_source();
    pwr <= 6'h08; wt(8);
    `CHK(src_sel, 2'h1)
    pwr <= 6'h28; wt(10);
    `CHK(src_sel, 2'h1)
    wt(20);
    `CHK(src_sel, 2'h0)
  endtask
  // eb: relays that stand before the flush; none may move while it runs
  task automatic shut(input logic [5:0] eb);
    int n;
    pwr <= 6'h0a;
    for (n = 0; n < 100 && !standby; n++) begin
      @(posedge aclk);
      if (flush_req) `CHK(byp, eb)
    end
    `CHK(standby, 1'b1)
  endtask
  task automatic t_shutdown();
    logic seen;
    seen = 1'b0;
    cmdw(A_CMD, 32'h14);
    shut(6'h00);
    `CHK(byp, 6'h1f)
    rd(A_STAT); `CHK(rd_data[2:0], 3'h3)
    pwr <= 6'h20; wt(30); pwr <= 6'h08; wt(5); pwr <= 6'h20; wt(40);
    `CHK(standby, 1'b1)
    repeat (60) begin
      @(posedge aclk);
      if (log_restore) seen = 1'b1;
    end
    `CHK(standby, 1'b0)
    `CHK(seen, 1'b1)
    slow <= 1'b0;
    shut(6'h1f);
    pwr <= 6'h0b; wt(8);
    `CHK(power_off, 1'b1)
  endtask
  initial begin
    wt(5);
    aresetn <= 1'b1;
    wt(3);
    t_reset();
    t_mirror();
    t_marker();
    t_bypass();
    t_fault();
    t_addr();
    t_source();
    t_shutdown();
    results();
  end
endmodule
`default_nettype wire
